//--- hw/fault_pkg.sv
package fault_pkg;
  // flag layout of status, mask and interrupt registers
  localparam int FAULT_W = 12;
  localparam int FLAG_W = 14;
  localparam int FLG_PRI_LOW = 0;
  localparam int FLG_PRI_HIGH = 1;
  localparam int FLG_POS_LOW = 2;
  localparam int FLG_POS_HIGH = 3;
  localparam int FLG_NEG_LOW = 4;
  localparam int FLG_NEG_HIGH = 5;
  localparam int FLG_OVERCURRENT = 6;
  localparam int FLG_SHORT = 7;
  localparam int FLG_DESAT = 8;
  localparam int FLG_SEC_SHUTDOWN = 9;
  localparam int FLG_CLOCK_MON = 10;
  localparam int FLG_INT_LINK = 11;
  localparam int FLG_PRI_WARN = 12;
  localparam int FLG_SEC_WARN = 13;
  // safe state groups, two select bits each
  localparam int SAFE_GROUPS = 8;
  localparam int CLEAR_BIT = 0;
  // register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_SAFE = 8'h08;
  localparam logic [7:0] OFS_CONTROL = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  // reset values
  localparam logic [FLAG_W-1:0] MASK_RESET = 14'h0000;
  localparam logic [FLAG_W-1:0] IRQ_MASK_RESET = 14'h0000;
  localparam logic [2*SAFE_GROUPS-1:0] SAFE_RESET = 16'h0000;
  typedef enum logic [1:0] {
    SAFE_PULL_LOW = 2'h0,
    SAFE_PULL_HIGH = 2'h1,
    SAFE_NONE = 2'h2
  } safe_action_t;
  // live fault conditions from the detectors
  typedef struct packed {
    logic pri_heat_shutdown;
    logic sec_heat_warn;
    logic pri_heat_warn;
    logic sec_heat_shutdown;
    logic desat;
    logic short_circuit;
    logic overcurrent;
    logic neg_high;
    logic neg_low;
    logic pos_high;
    logic pos_low;
    logic pri_high;
    logic pri_low;
  } fault_cond_t;
  // gate stage commands
  typedef struct packed {
    logic gate;
    logic sink_pull_low;
    logic source_pull_high;
  } gate_drive_t;
endpackage : fault_pkg

//--- hw/cond_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for asynchronous detector levels
module cond_sync #(
  parameter int W = 13
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // levels
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign q_out = sync_q;
endmodule : cond_sync

//--- hw/fault_response.sv
// The Avalon-MM register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module fault_response
  import fault_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // avalon-mm slave
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // detectors and gate command
  input wire fault_cond_t cond_in,
  input wire logic drive_in,
  // gate stage and alarms
  output gate_drive_t gate_out,
  output logic fault_alarm_n_out,
  output logic warning_alarm_n_out,
  output logic serial_enable_out,
  output logic irq_out
);
  fault_cond_t cond_s;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [FAULT_W-1:0] fault_q, fault_d, set_v;
  logic [1:0] warn_live, warn_prev_q, warn_rise, warn_pend_q, warn_pend_d;
  logic [FLAG_W-1:0] mask_q, irq_mask_q, irq_stat_q, irq_stat_d, status_v, irq_ev;
  logic [2*SAFE_GROUPS-1:0] safe_q;
  logic fault_alarm_n_q, serial_enable_q;
  gate_drive_t gate_q, gate_d;
  logic [SAFE_GROUPS-1:0] grp_act, grp_low, grp_high;
  logic low_req, high_req, suspend;

  cond_sync #(.W($bits(fault_cond_t))) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .d_in(cond_in),
    .q_out(cond_s)
  );

  // bus decode; every access is answered on the second cycle
  wire req = avs_read_in | avs_write_in;
  wire acc = req & ack_q;
  wire wr_en = acc & avs_write_in & ~suspend;
  wire rd_en = acc & avs_read_in & ~suspend;
  wire sel_status = avs_address_in == OFS_STATUS;
  wire sel_mask = avs_address_in == OFS_MASK;
  wire sel_safe = avs_address_in == OFS_SAFE;
  wire sel_control = avs_address_in == OFS_CONTROL;
  wire sel_irq_stat = avs_address_in == OFS_IRQ_STATUS;
  wire sel_irq_mask = avs_address_in == OFS_IRQ_MASK;
  wire clear_cmd = wr_en & sel_control & avs_writedata_in[CLEAR_BIT];
  wire status_read = rd_en & sel_status;
  wire irq_read = rd_en & sel_irq_stat;
  assign avs_waitrequest_out = req & ~ack_q;

  // primary supply and primary die trouble take the serial port away
  assign suspend = cond_s.pri_low | cond_s.pri_high | cond_s.pri_heat_shutdown;

  // conditions mapped onto the flag layout
  assign set_v[FLG_PRI_LOW] = cond_s.pri_low;
  assign set_v[FLG_PRI_HIGH] = cond_s.pri_high;
  assign set_v[FLG_POS_LOW] = cond_s.pos_low;
  assign set_v[FLG_POS_HIGH] = cond_s.pos_high;
  assign set_v[FLG_NEG_LOW] = cond_s.neg_low;
  assign set_v[FLG_NEG_HIGH] = cond_s.neg_high;
  assign set_v[FLG_OVERCURRENT] = cond_s.overcurrent;
  assign set_v[FLG_SHORT] = cond_s.short_circuit;
  assign set_v[FLG_DESAT] = cond_s.desat;
  assign set_v[FLG_SEC_SHUTDOWN] = cond_s.sec_heat_shutdown;
  assign set_v[FLG_CLOCK_MON] = cond_s.sec_heat_shutdown;
  assign set_v[FLG_INT_LINK] = cond_s.sec_heat_shutdown;

  // a present condition always wins over the clear command
  assign fault_d = set_v | (fault_q & {FAULT_W{~clear_cmd}});

  // warning flags are live; the alarm latches on a fresh rising edge only
  assign warn_live = {cond_s.sec_heat_warn, cond_s.pri_heat_warn};
  assign warn_rise = warn_live & ~warn_prev_q;
  assign warn_pend_d = (warn_rise & ~mask_q[FLG_SEC_WARN:FLG_PRI_WARN])
                     | (warn_pend_q & {2{~status_read}});
  assign status_v = {warn_live, fault_q};

  // safe state per group; short circuit and desaturation share a group
  genvar k;
  generate
    for (k = 0; k < SAFE_GROUPS; k++) begin : g_safe
      if (k == SAFE_GROUPS - 1) begin : g_pair
        assign grp_act[k] = (fault_q[FLG_SHORT] & ~mask_q[FLG_SHORT])
                          | (fault_q[FLG_DESAT] & ~mask_q[FLG_DESAT]);
      end else begin : g_one
        assign grp_act[k] = fault_q[k] & ~mask_q[k];
      end
      assign grp_low[k] = grp_act[k] & (safe_q[2*k+1:2*k] == SAFE_PULL_LOW);
      assign grp_high[k] = grp_act[k] & (safe_q[2*k+1:2*k] == SAFE_PULL_HIGH);
    end
  endgenerate

  // shutdown faults force the sink regardless of selection or mask
  assign low_req = (|grp_low) | fault_q[FLG_SEC_SHUTDOWN] | cond_s.pri_heat_shutdown;
  assign high_req = |grp_high;
  assign gate_d.sink_pull_low = low_req;
  assign gate_d.source_pull_high = high_req & ~low_req; // pull low wins a conflict
  assign gate_d.gate = low_req ? 1'b0 : (high_req ? 1'b1 : drive_in);

  // interrupt events: new flags and fresh warnings; a set beats a read clear
  assign irq_ev = {warn_rise, fault_d & ~fault_q};
  assign irq_stat_d = irq_ev | (irq_stat_q & {FLAG_W{~irq_read}});
  assign irq_out = |(irq_stat_q & irq_mask_q);

  // read data; unmapped offsets and suspended access read zero
  wire [31:0] rd_mux = suspend ? 32'h0000_0000 :
    sel_status ? {18'h00000, status_v} :
    sel_mask ? {18'h00000, mask_q} :
    sel_safe ? {16'h0000, safe_q} :
    sel_irq_stat ? {18'h00000, irq_stat_q} :
    sel_irq_mask ? {18'h00000, irq_mask_q} : 32'h0000_0000;

  // bus handshake and read data
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) rdata_q <= rd_mux;
    end
  end
  assign avs_readdata_out = rdata_q;

  // configuration registers; secondary faults leave them writable for the host rewrite
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      mask_q <= MASK_RESET;
      safe_q <= SAFE_RESET;
      irq_mask_q <= IRQ_MASK_RESET;
    end else if (wr_en) begin
      if (sel_mask) mask_q <= avs_writedata_in[FLAG_W-1:0];
      if (sel_safe) safe_q <= avs_writedata_in[2*SAFE_GROUPS-1:0];
      if (sel_irq_mask) irq_mask_q <= avs_writedata_in[FLAG_W-1:0];
    end
  end

  // flags, alarms and gate stage
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      fault_q <= '0;
      warn_prev_q <= 2'h0;
      warn_pend_q <= 2'h0;
      irq_stat_q <= '0;
      fault_alarm_n_q <= 1'b1;
      serial_enable_q <= 1'b1;
      gate_q <= '0;
    end else begin
      fault_q <= fault_d;
      warn_prev_q <= warn_live;
      warn_pend_q <= warn_pend_d;
      irq_stat_q <= irq_stat_d;
      fault_alarm_n_q <= ~|(fault_d & ~mask_q[FAULT_W-1:0]);
      serial_enable_q <= ~suspend;
      gate_q <= gate_d;
    end
  end

  assign gate_out = gate_q;
  assign fault_alarm_n_out = fault_alarm_n_q;
  assign warning_alarm_n_out = ~|warn_pend_q;
  assign serial_enable_out = serial_enable_q;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  a_pri_low_suspend: assert property (cond_s.pri_low |=> !serial_enable_q && fault_q[FLG_PRI_LOW])
    else $error("primary low did not flag or suspend");
  a_pri_high_flag: assert property (cond_s.pri_high |=> fault_q[FLG_PRI_HIGH] && !serial_enable_q)
    else $error("primary high not flagged");
  a_pos_high_alarm: assert property (cond_s.pos_high && !mask_q[FLG_POS_HIGH] && !suspend
    |=> !fault_alarm_n_q && serial_enable_q)
    else $error("secondary high alarm or access wrong");
  a_warn_no_gate: assert property (fault_q == '0 && !cond_s.pri_heat_shutdown
    |=> gate_q.gate == $past(drive_in) && !gate_q.sink_pull_low)
    else $error("gate disturbed without fault");
  a_sec_tsd_flags: assert property (cond_s.sec_heat_shutdown
    |=> fault_q[FLG_SEC_SHUTDOWN] && fault_q[FLG_CLOCK_MON] && fault_q[FLG_INT_LINK] ##1 gate_q.sink_pull_low)
    else $error("secondary shutdown flags or gate wrong");
  a_pri_tsd_low: assert property (cond_s.pri_heat_shutdown
    |=> gate_q.sink_pull_low && !gate_q.gate && !serial_enable_q)
    else $error("primary shutdown did not force low");
  a_flag_clear: assert property (clear_cmd && !set_v[FLG_OVERCURRENT] |=> !fault_q[FLG_OVERCURRENT])
    else $error("flag not cleared");
  a_flag_hold: assert property (fault_q[FLG_PRI_LOW] && !clear_cmd |=> fault_q[FLG_PRI_LOW])
    else $error("flag dropped without clear");
  a_safe_none: assert property (fault_q == 12'h040 && safe_q[13:12] == SAFE_NONE && !mask_q[FLG_OVERCURRENT]
    && !cond_s.pri_heat_shutdown |=> gate_q.gate == $past(drive_in) && !gate_q.sink_pull_low)
    else $error("no-action safe state changed the gate");
  a_warn_release: assert property (status_read && warn_rise == 2'h0 |=> warning_alarm_n_out)
    else $error("warning alarm not released by read");
  a_mask_quiet: assert property (mask_q[FLG_OVERCURRENT] && fault_d == 12'h040
    |=> fault_alarm_n_q && fault_q[FLG_OVERCURRENT])
    else $error("masked fault raised alarm or lost its flag");
endmodule : fault_response

//--- tb/host_model.sv
`timescale 1ns/1ps
// bus-side host, one avalon access at a time
module host_model (
  // clock
  input wire logic clk_sys_in,
  // avalon-mm master
  output logic [7:0] avs_address_out,
  output logic avs_read_out,
  output logic avs_write_out,
  output logic [31:0] avs_writedata_out,
  input wire logic [31:0] avs_readdata_in,
  input wire logic avs_waitrequest_in
);
  // idle bus from time zero
  initial begin
    avs_address_out = 8'h00;
    avs_read_out = 1'b0;
    avs_write_out = 1'b0;
    avs_writedata_out = 32'h00000000;
  end
  // request held until waitrequest is low at an edge; no cycle count assumed
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    logic ok;
    ok = 1'b0;
    @(posedge clk_sys_in);
    avs_address_out <= a;
    avs_writedata_out <= d;
    avs_read_out <= ~w;
    avs_write_out <= w;
    // waitrequest and read data are taken together at the rising edge only
    while (!ok) begin
      @(posedge clk_sys_in);
      if (avs_waitrequest_in === 1'b0) begin
        ok = 1'b1;
        q = avs_readdata_in;
      end
    end
    avs_read_out <= 1'b0;
    avs_write_out <= 1'b0;
  endtask : xfer
endmodule : host_model

//--- tb/supply_thermal_fault_response_tb_top.sv
`timescale 1ns/1ps
module supply_thermal_fault_response_tb_top import fault_pkg::*;;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic [12:0] cond = 13'h0000;
  logic drv = 1'b1;
  logic [7:0] addr;
  logic rd, wr, wreq, fa_n, wa_n, sen, irq;
  logic [31:0] wdata, rdata, q;
  gate_drive_t gate;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  // 40 MHz clock
  always #12.5 clk_sys_in = ~clk_sys_in;
  fault_response i_fault_response (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .cond_in(cond), .drive_in(drv), .gate_out(gate),
    .fault_alarm_n_out(fa_n), .warning_alarm_n_out(wa_n), .serial_enable_out(sen), .irq_out(irq));
  host_model i_host_model (.clk_sys_in(clk_sys_in), .avs_address_out(addr), .avs_read_out(rd),
    .avs_write_out(wr), .avs_writedata_out(wdata), .avs_readdata_in(rdata), .avs_waitrequest_in(wreq));
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    i_host_model.xfer(1'b1, a, d, q);
  endtask : wr32
  task automatic rd32(input logic [7:0] a, input logic [31:0] e);
    i_host_model.xfer(1'b0, a, 32'h00000000, q);
    chk(q, e);
  endtask : rd32
  // detector level changes, then room for the 4-edge response
  task automatic setc(input int i, input logic v);
    @(posedge clk_sys_in);
    cond[i] <= v;
    repeat (6) @(posedge clk_sys_in);
  endtask : setc
  // cycle ceiling; a hang counts as a mismatch
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end
  // main sequence
  initial begin
    repeat (10) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    wr32(8'h18, 32'hFFFFFFFF);
    rd32(8'h18, 32'h00000000);
    rd32(OFS_MASK, 32'h00000000);
    rd32(OFS_SAFE, 32'h00000000);
    chk({fa_n, wa_n, sen, irq}, 32'h0000000E);
    $display("reset test done");
    for (int i = 3; i < 9; i++) begin
      setc(i, 1'b1);
      chk({fa_n, gate.sink_pull_low, sen, irq}, 32'h00000006);
      wr32(OFS_CONTROL, 32'h00000001);
      rd32(OFS_STATUS, 32'h00000001 << i);
      setc(i, 1'b0);
      chk(fa_n, 32'h00000000);
      wr32(OFS_CONTROL, 32'h00000001);
      rd32(OFS_STATUS, 32'h00000000);
      chk(fa_n, 32'h00000001);
    end
    $display("fault test done");
    wr32(OFS_MASK, 32'h00000040);
    setc(6, 1'b1);
    chk({fa_n, gate.gate, gate.sink_pull_low}, 32'h00000006);
    rd32(OFS_STATUS, 32'h00000040);
    setc(6, 1'b0);
    wr32(OFS_CONTROL, 32'h00000001);
    wr32(OFS_MASK, 32'h00000000);
    // events of the earlier tests are still pending; one read clears them all
    rd32(OFS_IRQ_STATUS, 32'h000001F8);
    wr32(OFS_IRQ_MASK, 32'h00000040);
    // the three safe-state codes on the overcurrent group
    for (int s = 0; s < 3; s++) begin
      wr32(OFS_SAFE, s << 12);
      setc(6, 1'b1);
      chk({gate.gate, gate.sink_pull_low, gate.source_pull_high}, (s == 2) ? 4 : (s == 0) ? 2 : 5);
      // with no action chosen the gate must keep following the normal command
      if (s == 2) begin
        drv <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        chk(gate.gate, 32'h00000000);
        drv <= 1'b1;
      end
      chk(irq, 32'h00000001);
      rd32(OFS_IRQ_STATUS, 32'h00000040);
      // the read clears the status at the accepting edge; look one edge later
      @(posedge clk_sys_in);
      chk(irq, 32'h00000000);
      setc(6, 1'b0);
      wr32(OFS_CONTROL, 32'h00000001);
    end
    wr32(OFS_SAFE, 32'h00000000);
    $display("safe state test done");
    wr32(OFS_MASK, 32'h00002000);
    for (int i = 0; i < 13; i = (i == 1) ? 12 : i + 1) begin
      setc(i, 1'b1);
      chk({sen, gate.sink_pull_low, fa_n}, (i == 12) ? 3 : 2);
      wr32(OFS_MASK, 32'h00000000);
      rd32(OFS_MASK, 32'h00000000);
      setc(i, 1'b0);
      chk(sen, 32'h00000001);
      rd32(OFS_STATUS, (i == 12) ? 0 : 1 << i);
      rd32(OFS_MASK, 32'h00002000);
      wr32(OFS_CONTROL, 32'h00000001);
    end
    wr32(OFS_MASK, 32'h00000000);
    setc(2, 1'b1);
    chk({sen, fa_n}, 32'h00000002);
    setc(2, 1'b0);
    wr32(OFS_SAFE, 32'h00000000);
    setc(9, 1'b1);
    chk({fa_n, gate.sink_pull_low}, 32'h00000001);
    rd32(OFS_STATUS, 32'h00000E04);
    setc(9, 1'b0);
    wr32(OFS_CONTROL, 32'h00000001);
    wr32(OFS_MASK, 32'h00000000);
    $display("supply test done");
    for (int i = 10; i < 12; i++) begin
      setc(i, 1'b1);
      chk({wa_n, fa_n, sen, gate.gate}, 32'h00000007);
      rd32(OFS_STATUS, 32'h00000004 << i);
      repeat (4) @(posedge clk_sys_in);
      chk(wa_n, 32'h00000001);
      setc(i, 1'b0);
      rd32(OFS_STATUS, 32'h00000000);
      setc(i, 1'b1);
      chk(wa_n, 32'h00000000);
      setc(i, 1'b0);
    end
    $display("warning test done");
    test_done();
  end
endmodule : supply_thermal_fault_response_tb_top
